// >>> ihs_params.svh
// Purpose: constants for the image histogram statistics block
// Assumes: included by its bare name, after the package where types are needed
// Notes:   register byte address is four times the register index
`ifndef IHS_PARAMS_SVH
`define IHS_PARAMS_SVH

// register indices and byte addresses
`define IHS_IDX_HIST_COUNT      8'h46
`define IHS_IDX_SAMPLE_SPACING  8'h47
`define IHS_IDX_OUT_WIDTH       8'h48
`define IHS_IDX_DPATH_WIDTH     8'h49
`define IHS_IDX_STATUS          8'h4a
`define IHS_ADDR_HIST_COUNT     12'h118
`define IHS_ADDR_SAMPLE_SPACING 12'h11c
`define IHS_ADDR_OUT_WIDTH      12'h120
`define IHS_ADDR_DPATH_WIDTH    12'h124
`define IHS_ADDR_STATUS         12'h128

// reset values
`define IHS_RST_HIST_COUNT      3'h0
`define IHS_RST_SAMPLE_SPACING  8'h08
`define IHS_RST_OUT_WIDTH       2'h2
`define IHS_RST_DPATH_WIDTH     1'h1

// field values
`define IHS_OUT_WIDTH_10        2'h1
`define IHS_OUT_WIDTH_12        2'h2
`define IHS_DPATH_12            1'h1
`define IHS_MIN_SPACING         8'h08
`define IHS_MAX_HISTS           3'h5

// histogram layout
`define IHS_NUM_HISTS           5
`define IHS_NUM_BINS            34
`define IHS_BIN_ZERO            6'h00
`define IHS_BIN_FULL            6'h21
`define IHS_BIN_OFFSET          6'h01
`define IHS_ELEM_MARKER         6'h00
`define IHS_ELEM_ID             6'h01
`define IHS_ELEM_FIRST_BIN      6'h02
`define IHS_LAST_WORD           7'h46
`define IHS_MARKER_VALUE        24'hff_ffff
`define IHS_FULL_12             12'hfff
`define IHS_FULL_10             10'h3ff

`endif

// >>> ihs_pkg.sv
// Purpose: shared types of the image histogram statistics block
// Assumes: nothing beyond the constants header
// Notes:   one-hot state codes written out
package ihs_pkg;

	typedef enum logic [1:0] {
		IHS_IDLE = 2'b01,
		IHS_SEND = 2'b10
	} ihs_tx_state_t;

	typedef logic [11:0] ihs_word_t;

endpackage

// >>> ihs_stats.sv
// Purpose: per-frame histogram statistics for the top and bottom halves
// Assumes: pixels, row and frame strobes come from logic on ref_clk_i
// Notes:   APB slave answers every access after one wait state
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "ihs_params.svh"

module ihs_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk_i,
	input  wire logic             reset_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_q;
	logic [PW-1:0]    rd_q;
	logic [CW-1:0]    cnt_q;
	logic [CW-1:0]    cnt_d;
	logic             push;
	logic             pop;

	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rd_q];

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + CW'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	// ready is registered so the source never sees a combinational path
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cnt_q      <= '0;
			in_ready_o <= 1'b1;
		end else begin
			cnt_q      <= cnt_d;
			in_ready_o <= (cnt_d != CW'(DEPTH));
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

endmodule // ihs_fifo

// What this block does
// - field zero sends nothing; one to five selects histograms sent per frame
// - histograms go out in order all, even/even, even/odd, odd/even, odd/odd
// - larger spacing samples fewer pixels; values under eight are not allowed
// - each frame builds one histogram per colour phase plus a combined one
// - only exposure group L pixels are counted
// - each histogram also carries black-clipped and white-clipped counts
// - top and bottom halves produce separate sets; receiver adds them
// - statistics use only the first data lane, one histogram per row period
// - statistics valid flag marks every histogram word on the control lane
// - each element is two words, low part first
// - element zero is an all-ones marker, element one is the identifier
// - identifier is 0 all, 1 ee, 2 eo, 3 oe, 4 oo
// - element 2 zero count, 3 to 34 equal bins, 35 full-scale count
// - zero pixels also land in lowest bin, full-scale pixels in highest
// - sampled pixels are spread evenly, best coverage at spacing eight
// - only 71 of 72 words are sent; last full-scale word is dropped
// - output width 1 gives 10-bit words, 2 gives 12-bit words
module ihs_stats #(
	parameter int CNT_W      = 24,
	parameter int FIFO_DEPTH = 8,
	parameter int PIX_W      = 12
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  reset_i,
	input  wire logic [11:0]           paddr_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic [1:0]            pix_valid_i,
	input  wire logic [1:0][PIX_W-1:0] pix_data_i,
	input  wire logic [1:0]            pix_row_odd_i,
	input  wire logic [1:0]            pix_col_odd_i,
	input  wire logic [1:0]            pix_group_l_i,
	output logic      [1:0]            pix_ready_o,
	input  wire logic                  frame_start_i,
	input  wire logic                  frame_end_i,
	input  wire logic                  row_start_i,
	output ihs_pkg::ihs_word_t [1:0]   first_data_lane_o,
	output logic      [1:0]            stats_valid_flag_o
);
	import ihs_pkg::*;

	localparam int FW = PIX_W + 3;

	logic [2:0]       hist_sel_q;
	logic [7:0]       spacing_q;
	logic [1:0]       out_width_q;
	logic             dpath_q;
	logic             apb_access;
	logic             apb_write;
	logic [31:0]      rd_val;
	logic             rd_hit;

	logic [1:0]       f_valid;
	logic [1:0]       f_ready;
	logic [FW-1:0]    f_data [2];
	logic [1:0]       take;
	logic [7:0]       samp_q [2];
	logic [7:0]       spacing_eff;
	logic [2:0]       nhist_live;

	logic [CNT_W-1:0] cnt_q [2][`IHS_NUM_HISTS][`IHS_NUM_BINS];
	logic [1:0]       clr_pend_q;
	logic [1:0]       armed_q;
	ihs_tx_state_t    state_q [2];
	logic [6:0]       word_q [2];
	logic [2:0]       hist_q [2];
	logic [2:0]       nhist_q [2];
	ihs_word_t        word_val [2];

	// regular bin slot 1..32 from the top five bits of the active width
	function automatic logic [5:0] bin_of(input logic [PIX_W-1:0] pix, input logic w12);
		logic [4:0] top;
		top = w12 ? pix[11:7] : pix[9:5];
		bin_of = {1'b0, top} + `IHS_BIN_OFFSET;
	endfunction

	function automatic logic is_full(input logic [PIX_W-1:0] pix, input logic w12);
		is_full = w12 ? (pix == `IHS_FULL_12) : (pix[9:0] == `IHS_FULL_10);
	endfunction

	function automatic ihs_word_t half_of(input logic [23:0] elem, input logic hi,
			input logic [1:0] ow);
		if (ow == `IHS_OUT_WIDTH_10) begin
			half_of = {2'b00, hi ? elem[19:10] : elem[9:0]};
		end else begin
			half_of = hi ? elem[23:12] : elem[11:0];
		end
	endfunction

	// values below the minimum would break the spread, so clamp
	assign spacing_eff = (spacing_q < `IHS_MIN_SPACING) ? `IHS_MIN_SPACING : spacing_q;
	assign nhist_live  = (hist_sel_q > `IHS_MAX_HISTS) ? `IHS_MAX_HISTS : hist_sel_q;

	// APB slave: one wait state, writes land on the completing edge
	assign apb_access = psel_i & penable_i;
	assign apb_write  = apb_access & pready_o & pwrite_i;

	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		case (paddr_i)
			`IHS_ADDR_HIST_COUNT:     rd_val[2:0] = hist_sel_q;
			`IHS_ADDR_SAMPLE_SPACING: rd_val[7:0] = spacing_q;
			`IHS_ADDR_OUT_WIDTH:      rd_val[1:0] = out_width_q;
			`IHS_ADDR_DPATH_WIDTH:    rd_val[0]   = dpath_q;
			`IHS_ADDR_STATUS:         rd_val[3:0] = {clr_pend_q, armed_q};
			default:                  rd_hit      = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= '0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= apb_access & ~pready_o;
			prdata_o  <= (apb_access & ~pready_o & ~pwrite_i) ? rd_val : '0;
			pslverr_o <= apb_access & ~pready_o & (~rd_hit | (pwrite_i &
				(paddr_i == `IHS_ADDR_STATUS)));
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			hist_sel_q  <= `IHS_RST_HIST_COUNT;
			spacing_q   <= `IHS_RST_SAMPLE_SPACING;
			out_width_q <= `IHS_RST_OUT_WIDTH;
			dpath_q     <= `IHS_RST_DPATH_WIDTH;
		end else if (apb_write) begin
			case (paddr_i)
				`IHS_ADDR_HIST_COUNT:     hist_sel_q  <= pwdata_i[2:0];
				`IHS_ADDR_SAMPLE_SPACING: spacing_q   <= pwdata_i[7:0];
				`IHS_ADDR_OUT_WIDTH:      out_width_q <= pwdata_i[1:0];
				`IHS_ADDR_DPATH_WIDTH:    dpath_q     <= pwdata_i[0];
				default:                  ;
			endcase
		end
	end

	// pixel buffers; drain stalls while a side transmits or clears
	for (genvar s = 0; s < 2; s++) begin : g_side
		ihs_fifo #(
			.WIDTH (FW),
			.DEPTH (FIFO_DEPTH)
		) u_fifo (
			.ref_clk_i   (ref_clk_i),
			.reset_i     (reset_i),
			.in_valid_i  (pix_valid_i[s]),
			.in_data_i   ({pix_group_l_i[s], pix_row_odd_i[s], pix_col_odd_i[s],
				pix_data_i[s]}),
			.in_ready_o  (pix_ready_o[s]),
			.out_valid_o (f_valid[s]),
			.out_data_o  (f_data[s]),
			.out_ready_i (f_ready[s])
		);
		assign f_ready[s] = ~armed_q[s] & ~clr_pend_q[s];
		// sampling counter runs across rows so picks spread evenly
		assign take[s] = f_valid[s] & f_ready[s] & (samp_q[s] == '0) &
			f_data[s][FW-1];
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			for (int s = 0; s < 2; s++) begin
				samp_q[s] <= '0;
			end
		end else begin
			for (int s = 0; s < 2; s++) begin
				if (clr_pend_q[s]) begin
					samp_q[s] <= '0;
				end else if (f_valid[s] && f_ready[s]) begin
					samp_q[s] <= (samp_q[s] >= spacing_eff - 8'h01) ? '0 :
						samp_q[s] + 8'h01;
				end
			end
		end
	end

	// a frame start during transmit waits until the last histogram is out
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			clr_pend_q <= '0;
		end else begin
			for (int s = 0; s < 2; s++) begin
				if (frame_start_i) begin
					clr_pend_q[s] <= 1'b1;
				end else if (!armed_q[s]) begin
					clr_pend_q[s] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			for (int s = 0; s < 2; s++) begin
				for (int h = 0; h < `IHS_NUM_HISTS; h++) begin
					for (int b = 0; b < `IHS_NUM_BINS; b++) begin
						cnt_q[s][h][b] <= '0;
					end
				end
			end
		end else begin
			for (int s = 0; s < 2; s++) begin
				for (int h = 0; h < `IHS_NUM_HISTS; h++) begin
					for (int b = 0; b < `IHS_NUM_BINS; b++) begin
						if (clr_pend_q[s] && !armed_q[s]) begin
							cnt_q[s][h][b] <= '0;
						end else if (take[s] && (h == 0 ||
								h == 1 + int'(f_data[s][PIX_W+1:PIX_W])) && (
								6'(b) == bin_of(f_data[s][PIX_W-1:0], dpath_q) ||
								(6'(b) == `IHS_BIN_ZERO &&
									f_data[s][PIX_W-1:0] == '0) ||
								(6'(b) == `IHS_BIN_FULL &&
									is_full(f_data[s][PIX_W-1:0], dpath_q)))) begin
							cnt_q[s][h][b] <= cnt_q[s][h][b] + CNT_W'(1);
						end
					end
				end
			end
		end
	end

	// element words: marker, identifier, then the 34 counters
	always_comb begin
		logic [5:0]  elem;
		logic [23:0] val;
		elem = '0;
		val  = '0;
		for (int s = 0; s < 2; s++) begin
			elem = word_q[s][6:1];
			if (elem == `IHS_ELEM_MARKER) begin
				val = `IHS_MARKER_VALUE;
			end else if (elem == `IHS_ELEM_ID) begin
				val = {21'h00_0000, hist_q[s]};
			end else begin
				val = 24'(cnt_q[s][hist_q[s] % `IHS_NUM_HISTS]
					[(elem - `IHS_ELEM_FIRST_BIN) % `IHS_NUM_BINS]);
			end
			word_val[s] = half_of(val, word_q[s][0], out_width_q);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			for (int s = 0; s < 2; s++) begin
				state_q[s] <= IHS_IDLE;
				word_q[s]  <= '0;
				hist_q[s]  <= '0;
				nhist_q[s] <= '0;
			end
			armed_q <= '0;
		end else begin
			for (int s = 0; s < 2; s++) begin
				case (state_q[s])
					IHS_IDLE: begin
						if (frame_end_i && !armed_q[s] && nhist_live != 3'h0) begin
							armed_q[s] <= 1'b1;
							hist_q[s]  <= '0;
							nhist_q[s] <= nhist_live;
						end else if (armed_q[s] && row_start_i) begin
							state_q[s] <= IHS_SEND;
							word_q[s]  <= '0;
						end
					end
					IHS_SEND: begin
						if (word_q[s] == `IHS_LAST_WORD) begin
							state_q[s] <= IHS_IDLE;
							hist_q[s]  <= hist_q[s] + 3'h1;
							if (hist_q[s] + 3'h1 == nhist_q[s]) begin
								armed_q[s] <= 1'b0;
							end
						end else begin
							word_q[s] <= word_q[s] + 7'h01;
						end
					end
					default: state_q[s] <= IHS_IDLE;
				endcase
			end
		end
	end

	// first data lane carries statistics only; idle word is zero
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			first_data_lane_o  <= '0;
			stats_valid_flag_o <= '0;
		end else begin
			for (int s = 0; s < 2; s++) begin
				stats_valid_flag_o[s] <= (state_q[s] == IHS_SEND);
				first_data_lane_o[s]  <= (state_q[s] == IHS_SEND) ? word_val[s] : '0;
			end
		end
	end

endmodule // ihs_stats

// >>> ihs_rx_model.sv
// Purpose: receiver model for one statistics lane
// Assumes: one word per cycle while valid is high
// Notes:   keeps the raw words; pairing is left to the reader
`timescale 1ns/10ps
module ihs_rx_model (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  ihs_pkg::ihs_word_t word_i,
	input  wire logic          vld_i,
	output ihs_pkg::ihs_word_t w_o[72],
	output logic [6:0]         nw_o,
	output logic               done_o
);
	import ihs_pkg::*;
	logic [6:0] idx_q;
	// words 2k and 2k+1 hold element k, low part first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idx_q  <= 7'h00;
			nw_o   <= 7'h00;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (vld_i) begin
				w_o[idx_q] <= word_i;
				idx_q      <= idx_q + 7'h01;
			end else if (idx_q != 7'h00) begin
				// short count kept; full-scale bin is not trusted
				nw_o   <= idx_q;
				done_o <= 1'b1;
				idx_q  <= 7'h00;
			end
		end
	end
endmodule // ihs_rx_model

// >>> ihs_stats_assertions.sv
// Purpose: port checks for ihs_stats
// Assumes: one clock, sync reset
// Notes:   side 0 run length counted in helper logic
`timescale 1ns/10ps
module ihs_stats_assertions (
	input wire logic                ref_clk_i,
	input wire logic                reset_i,
	input wire logic                psel_i,
	input wire logic                penable_i,
	input wire logic                pready_o,
	input wire logic                pslverr_o,
	input wire logic                row_start_i,
	input ihs_pkg::ihs_word_t [1:0] first_data_lane_o,
	input wire logic [1:0]          stats_valid_flag_o
);
	import ihs_pkg::*;
	logic [6:0] run_q;
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !stats_valid_flag_o[0]) run_q <= 7'h00;
		else run_q <= run_q + 7'h01;
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	property p_rdy; psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o; endproperty
	a_rdy: assert property (p_rdy) else $error("late answer");
	property p_err; pslverr_o |-> pready_o; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_start0; $rose(stats_valid_flag_o[0]) |-> $past(row_start_i, 2); endproperty
	a_start0: assert property (p_start0) else $error("top start");
	property p_start1; $rose(stats_valid_flag_o[1]) |-> $past(row_start_i, 2); endproperty
	a_start1: assert property (p_start1) else $error("bottom start");
	property p_len; $fell(stats_valid_flag_o[0]) |-> run_q == 7'h47; endproperty
	a_len: assert property (p_len) else $error("word count");
	property p_mark;
		$rose(stats_valid_flag_o[0]) |-> (first_data_lane_o[0][9:0] == 10'h3ff) [*2];
	endproperty
	a_mark: assert property (p_mark) else $error("marker");
	property p_idle; !stats_valid_flag_o[0] |-> first_data_lane_o[0] == 12'h000; endproperty
	a_idle: assert property (p_idle) else $error("idle lane");
	property p_rst; $past(reset_i) |-> stats_valid_flag_o == 2'b00; endproperty
	a_rst: assert property (p_rst) else $error("valid after reset");
	c_top: cover property ($rose(stats_valid_flag_o[0]));
	c_bot: cover property ($rose(stats_valid_flag_o[1]));
	c_err: cover property (pslverr_o);
endmodule // ihs_stats_assertions

bind ihs_stats ihs_stats_assertions u_ihs_stats_assertions (
	.ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .row_start_i(row_start_i),
	.first_data_lane_o(first_data_lane_o), .stats_valid_flag_o(stats_valid_flag_o));

// >>> tb_top.sv
// Purpose: self-checking bench for ihs_stats
// Assumes: both lanes watched by receiver models
// Notes:   only the top side gets pixels; bottom must stay empty
`timescale 1ns/10ps
`include "ihs_params.svh"
module tb_top;
	import ihs_pkg::*;
	logic            clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, fs = 0, fe = 0, rs = 0, e;
	logic [11:0]     paddr = 12'h000;
	logic [31:0]     pwdata = 32'h0000_0000, prdata, r;
	logic            pready, pslverr, dn0, dn1;
	logic [1:0]      pv = 0, pro = 0, pco = 0, pl = 0, prdy, svf;
	logic [1:0][11:0] pd = '0;
	ihs_word_t [1:0] lane;
	ihs_word_t       w0[72], w1[72];
	logic [6:0]      nw0, nw1;
	int              error_cnt = 0, n_tests = 0;
	always #5 clk = ~clk;
	ihs_stats u_ihs_stats (.ref_clk_i(clk), .reset_i(rst), .paddr_i(paddr), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .pix_valid_i(pv), .pix_data_i(pd),
		.pix_row_odd_i(pro), .pix_col_odd_i(pco), .pix_group_l_i(pl), .pix_ready_o(prdy),
		.frame_start_i(fs), .frame_end_i(fe), .row_start_i(rs),
		.first_data_lane_o(lane), .stats_valid_flag_o(svf));
	ihs_rx_model u_ihs_rx_model (.clk_i(clk), .rst_i(rst), .word_i(lane[0]),
		.vld_i(svf[0]), .w_o(w0), .nw_o(nw0), .done_o(dn0));
	ihs_rx_model u_ihs_rx_model_b (.clk_i(clk), .rst_i(rst), .word_i(lane[1]),
		.vld_i(svf[1]), .w_o(w1), .nw_o(nw1), .done_o(dn1));
	task test_done;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk); psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
		@(posedge clk); pen <= 1;
		i = 0;
		do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin error_cnt++; test_done; end
		r = prdata; e = pslverr; psel <= 0; pen <= 0;
	endtask
	task strobe(input int k);
		@(posedge clk); if (k == 0) fs <= 1; else fe <= 1;
		@(posedge clk); fs <= 0; fe <= 0;
	endtask
	// pixels 0, 8, 16, 24 fall on the sampling grid; 16 is not group L
	task px(input int i);
		int n;
		@(posedge clk); pv[0] <= 1; pro[0] <= (i == 24); pl[0] <= (i != 16);
		pd[0] <= (i == 0) ? 12'h000 : (i == 8) ? 12'hfff : (i % 8 == 0) ? 12'h800 : 12'h123;
		n = 0;
		do begin @(posedge clk); n++; end while (prdy[0] !== 1'b1 && n < 50);
		if (n >= 50) begin error_cnt++; test_done; end
		pv[0] <= 0;
	endtask
	task row(input logic expect_hist);
		logic s;
		s = 0;
		@(posedge clk); rs <= 1;
		@(posedge clk); rs <= 0;
		repeat (100) begin @(posedge clk); if (dn0 === 1'b1) s = 1; end
		chk(s, expect_hist);
		if (expect_hist) begin
			chk(nw0, 71);
			chk(nw1, 71);
		end
	endtask
	task t_regs;
		apb(0, `IHS_ADDR_HIST_COUNT, 0); chk(r, 0);
		apb(0, `IHS_ADDR_SAMPLE_SPACING, 0); chk(r, 8);
		apb(0, `IHS_ADDR_OUT_WIDTH, 0); chk(r, 2);
		apb(1, `IHS_ADDR_HIST_COUNT, 5);
		apb(0, `IHS_ADDR_HIST_COUNT, 0); chk(r, 5);
		apb(0, 12'h000, 0); chk(e, 1);
		apb(1, `IHS_ADDR_STATUS, 32'h0000_000f); chk(e, 1);
	endtask
	task t_frame_full;
		strobe(0);
		for (int i = 0; i < 32; i++) px(i);
		repeat (20) @(posedge clk);
		strobe(1);
		for (int k = 0; k < 5; k++) begin
			row(1);
			chk(w0[0], 12'hfff);
			chk(w0[1], 12'hfff);
			chk(w0[2], k);
			chk(w0[3], 0);
			chk(w1[4], 0);
			if (k == 0) begin
				chk(w0[4], 1);
				chk(w0[6], 1);
				chk(w0[38], 1);
				chk(w0[68], 1);
				chk(w0[70], 1);
			end
			if (k == 1) chk(w0[38], 0);
			if (k == 3) chk(w0[38], 1);
		end
		row(0);
	endtask
	task t_frame_short;
		apb(1, `IHS_ADDR_OUT_WIDTH, 1);
		apb(1, `IHS_ADDR_HIST_COUNT, 1);
		strobe(0);
		repeat (5) @(posedge clk);
		strobe(1);
		row(1);
		chk(w0[0], 12'h3ff);
		chk(w0[4], 0);
		row(0);
		apb(1, `IHS_ADDR_HIST_COUNT, 0);
		strobe(0);
		strobe(1);
		row(0);
	endtask
	// spacing 16 picks pixels 0 and 16 only; the full-scale pixel 8 drops out
	task t_frame_sparse;
		apb(1, `IHS_ADDR_SAMPLE_SPACING, 16);
		apb(0, `IHS_ADDR_SAMPLE_SPACING, 0); chk(r, 16);
		apb(1, `IHS_ADDR_HIST_COUNT, 1);
		strobe(0);
		for (int i = 0; i < 32; i++) px(i);
		repeat (20) @(posedge clk);
		strobe(1);
		row(1);
		chk(w0[4], 1);
		chk(w0[6], 1);
		chk(w0[68], 0);
		chk(w0[38], 0);
		row(0);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		t_regs;
		t_frame_full;
		t_frame_short;
		t_frame_sparse;
		test_done;
	end
endmodule // tb_top
